// File: pbh_pkg.sv
/*
 * package for the primary bus takeover handshake: states and sizes.
 * assumes one clock (the processor phase clock) and a synchronous reset.
 */
// Behaviour
// - hold request async, may cost one extra cycle
// - disable bit drops hold, ignores further requests
// - no new primary access while request asserted
// - keep executing, stall only on bus access
// - one write may pend, second write stalls
// - ack low until one cycle after release
// - strobe, rw, address, data float during hold
package pbh_pkg;
    localparam int ADDR_W_DEF = 24;
    localparam int DATA_W_DEF = 32;
    localparam logic [1:0] HOLD_DLY_CYC = 2'h1; // ack release delay in phase cycles

    typedef enum logic [3:0] {
        PBH_IDLE    = 4'b0001,
        PBH_XFER    = 4'b0010,
        PBH_HELD    = 4'b0100,
        PBH_RELEASE = 4'b1000
    } pbh_state_e;
endpackage : pbh_pkg

// File: pbh_sync.sv
/*
 * two-flop synchroniser for the hold request.
 * assumes clk is the processor phase clock; reset value is the idle level.
 */
`timescale 1ns/1ps
module pbh_sync (
    input  wire logic clk,
    input  wire logic rst,
    input  wire logic async_in,
    output logic      sync_out
);
    logic meta_q;
    logic meta_d;
    logic sync_q;
    logic sync_d;

    // first stage feeds only the second stage
    always_comb begin
        meta_d = async_in;
        sync_d = meta_q;
    end

    // resets to high: request inactive
    always_ff @(posedge clk) begin
        if (rst) begin
            meta_q <= 1'b1;
            sync_q <= 1'b1;
        end else begin
            meta_q <= meta_d;
            sync_q <= sync_d;
        end
    end

    assign sync_out = sync_q;
endmodule : pbh_sync

// File: pbh_hold.sv
/*
 * primary bus takeover handshake: grants the external bus to another
 * master, floats the bus pins, lets the core run on until it needs the
 * bus, and parks one write while held.
 * assumes core requests are held until accepted (req and ready), and a
 * transfer lasts until bus_done.
 * assumes bus_done is raised by the far side only while an own transfer
 * runs, and that the pads apply the oe_n outputs, low meaning driven.
 * the request pin needs no timing relation to ref_clk.
 */
`timescale 1ns/1ps
module pbh_hold #(
    parameter int ADDR_W = pbh_pkg::ADDR_W_DEF,
    parameter int DATA_W = pbh_pkg::DATA_W_DEF
) (
    input  wire logic              ref_clk,
    input  wire logic              sys_rst,
    input  wire logic              bus_takeover_req_n,
    input  wire logic              takeover_disable,
    input  wire logic              core_req,
    input  wire logic              core_we,
    input  wire logic [ADDR_W-1:0] core_addr,
    input  wire logic [DATA_W-1:0] core_wdata,
    output logic                   core_ready,
    input  wire logic              bus_done,
    output logic                   bus_takeover_ack_n,
    output logic                   bus_strobe_n,
    output logic                   bus_strobe_oe_n,
    output logic                   bus_rw,
    output logic                   bus_rw_oe_n,
    output logic [ADDR_W-1:0]      bus_addr,
    output logic                   bus_addr_oe_n,
    output logic [DATA_W-1:0]      bus_data_out,
    output logic                   bus_data_oe_n,
    output logic                   write_pending
);
    import pbh_pkg::*;

    // request path and who may use the bus this cycle
    logic              req_sync_n;
    logic              want_hold;
    logic              bus_free;
    logic              start_core;
    logic              start_pend;
    logic              park_write;
    logic              xfer_end;

    // handshake state
    pbh_state_e        state_q;
    pbh_state_e        state_d;
    logic [1:0]        rel_cnt_q;
    logic [1:0]        rel_cnt_d;
    logic              ack_n_q;
    logic              ack_n_d;

    // parked write flag and bus pin registers
    logic              pend_q;
    logic              pend_d;
    logic              rw_q;
    logic              rw_d;
    logic [ADDR_W-1:0] addr_q;
    logic [ADDR_W-1:0] addr_d;
    logic [DATA_W-1:0] data_q;
    logic [DATA_W-1:0] data_d;
    logic              strobe_n_q;
    logic              strobe_n_d;

    // async request brought into the clock domain
    pbh_sync u_sync (
        .clk      (ref_clk),
        .rst      (sys_rst),
        .async_in (bus_takeover_req_n),
        .sync_out (req_sync_n)
    );

    // the disable bit masks the request entirely
    assign want_hold = !req_sync_n && !takeover_disable;

    // bus may start a cycle only when idle and nobody asks for it
    assign bus_free   = (state_q == PBH_IDLE) && !want_hold;
    assign start_pend = bus_free && pend_q;
    assign start_core = bus_free && !pend_q && core_req;

    // a write taken without launching parks; a transfer ends on bus_done
    assign park_write = core_ready && core_we && !start_core;
    assign xfer_end   = (state_q == PBH_XFER) && bus_done;

    // core stalls only when it needs the bus and can't get it; one write
    // may park while held, a second write stalls
    always_comb begin
        core_ready = start_core;
        if (core_req && core_we && !pend_q && (state_q != PBH_XFER) && !bus_free) begin
            core_ready = 1'b1;
        end
    end

    // handshake state: the grant is only given from idle, so it always
    // falls on a boundary between own transfers
    always_comb begin
        state_d   = state_q;
        rel_cnt_d = rel_cnt_q;
        ack_n_d   = ack_n_q;
        case (state_q)
            PBH_IDLE: begin
                if (want_hold) begin
                    state_d = PBH_HELD;
                    ack_n_d = 1'b0;
                end else if (start_pend || start_core) begin
                    state_d = PBH_XFER;
                end
            end
            PBH_XFER: begin
                // no grant mid-transfer; wait for the cycle to finish
                if (bus_done) begin
                    state_d = PBH_IDLE;
                end
            end
            PBH_HELD: begin
                if (takeover_disable) begin
                    state_d = PBH_IDLE;
                    ack_n_d = 1'b1;
                end else if (req_sync_n) begin
                    state_d   = PBH_RELEASE;
                    rel_cnt_d = HOLD_DLY_CYC;
                end
            end
            PBH_RELEASE: begin
                // ack stays low one phase cycle after the request returns
                if (rel_cnt_q > 2'h1) begin
                    rel_cnt_d = rel_cnt_q - 2'h1;
                end else begin
                    state_d = PBH_IDLE;
                    ack_n_d = 1'b1;
                end
            end
            default: begin
                // an upset state drops the grant rather than hang the bus
                state_d = PBH_IDLE;
                ack_n_d = 1'b1;
            end
        endcase
    end

    // handshake registers
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            state_q   <= PBH_IDLE;
            rel_cnt_q <= 2'h0;
            ack_n_q   <= 1'b1;
        end else begin
            state_q   <= state_d;
            rel_cnt_q <= rel_cnt_d;
            ack_n_q   <= ack_n_d;
        end
    end

    // parked write flag: parking needs an empty slot and launching needs a
    // full one, so set and clear never fall in the same cycle
    always_comb begin
        pend_d = pend_q;
        if (park_write) begin
            pend_d = 1'b1;
        end else if (start_pend) begin
            pend_d = 1'b0;
        end
    end

    // parked write register
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            pend_q <= 1'b0;
        end else begin
            pend_q <= pend_d;
        end
    end

    // bus pin values: a parked write keeps its address and data in the pin
    // registers, which is safe because no own transfer runs while it parks
    always_comb begin
        rw_d       = rw_q;
        addr_d     = addr_q;
        data_d     = data_q;
        strobe_n_d = strobe_n_q;
        if (park_write) begin
            addr_d = core_addr;
            data_d = core_wdata;
        end
        if (start_pend) begin
            rw_d       = 1'b0;
            strobe_n_d = 1'b0;
        end else if (start_core) begin
            rw_d       = !core_we;
            addr_d     = core_addr;
            data_d     = core_wdata;
            strobe_n_d = 1'b0;
        end else if (xfer_end || (state_q != PBH_XFER)) begin
            // outside a transfer the strobe is always idle
            strobe_n_d = 1'b1;
        end
    end

    // bus pin registers
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            rw_q       <= 1'b1;
            addr_q     <= '0;
            data_q     <= '0;
            strobe_n_q <= 1'b1;
        end else begin
            rw_q       <= rw_d;
            addr_q     <= addr_d;
            data_q     <= data_d;
            strobe_n_q <= strobe_n_d;
        end
    end

    // pins float (enable high) whenever the grant is out
    assign bus_strobe_oe_n = !ack_n_q;
    assign bus_rw_oe_n     = !ack_n_q;
    assign bus_addr_oe_n   = !ack_n_q;
    assign bus_data_oe_n   = !ack_n_q || rw_q;

    assign bus_takeover_ack_n = ack_n_q;
    assign bus_strobe_n       = strobe_n_q;
    assign bus_rw             = rw_q;
    assign bus_addr           = addr_q;
    assign bus_data_out       = data_q;
    assign write_pending      = pend_q;
endmodule : pbh_hold

// File: pbh_hold_properties.sv
/* checker for the takeover handshake pins of pbh_hold.
   assumes it is bound into pbh_hold and sees only its ports. */
`timescale 1ns/1ps
module pbh_hold_properties (
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic bus_takeover_req_n,
    input wire logic takeover_disable,
    input wire logic core_req,
    input wire logic core_we,
    input wire logic core_ready,
    input wire logic bus_takeover_ack_n,
    input wire logic bus_strobe_n,
    input wire logic bus_strobe_oe_n,
    input wire logic bus_rw_oe_n,
    input wire logic bus_addr_oe_n,
    input wire logic bus_data_oe_n,
    input wire logic write_pending
);
    // one phase-clock domain, so one clocking and one disable
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (sys_rst);
    a_held_float: assert property (!bus_takeover_ack_n |-> bus_strobe_oe_n && bus_data_oe_n
        && bus_rw_oe_n && bus_addr_oe_n)
        else $error("pins driven while granted");
    a_park_once: assert property (write_pending && core_req && core_we |-> !core_ready)
        else $error("second write taken while one is parked");
    a_pins_back: assert property ($rose(bus_takeover_ack_n) |-> !bus_strobe_oe_n)
        else $error("pins still floating");
    a_held_quiet: assert property (!bus_takeover_ack_n |-> bus_strobe_n)
        else $error("own cycle while granted");
    a_grant_edge: assert property ($fell(bus_takeover_ack_n) |-> $past(bus_strobe_n))
        else $error("grant inside a transfer");
    a_drop_off: assert property (takeover_disable |=> bus_takeover_ack_n)
        else $error("grant while disabled");
    a_read_wait: assert property (!bus_takeover_ack_n && core_req && !core_we |-> !core_ready)
        else $error("read taken while granted");
    // a quiet bus must grant two edges after the first low sample
    a_ack_soon: assert property ($fell(bus_takeover_req_n) ##0 (bus_strobe_n && !core_req
        && !write_pending && !takeover_disable && !bus_takeover_req_n)[*3] |=> !bus_takeover_ack_n)
        else $error("late grant");
    a_ack_free: assert property ($rose(bus_takeover_req_n) && !bus_takeover_ack_n
        && !takeover_disable |-> !bus_takeover_ack_n [*4] ##1 bus_takeover_ack_n)
        else $error("release timing");
endmodule : pbh_hold_properties
bind pbh_hold pbh_hold_properties i_props (
    .ref_clk            (ref_clk),
    .sys_rst            (sys_rst),
    .bus_takeover_req_n (bus_takeover_req_n),
    .takeover_disable   (takeover_disable),
    .core_req           (core_req),
    .core_we            (core_we),
    .core_ready         (core_ready),
    .bus_takeover_ack_n (bus_takeover_ack_n),
    .bus_strobe_n       (bus_strobe_n),
    .bus_strobe_oe_n    (bus_strobe_oe_n),
    .bus_rw_oe_n        (bus_rw_oe_n),
    .bus_addr_oe_n      (bus_addr_oe_n),
    .bus_data_oe_n      (bus_data_oe_n),
    .write_pending      (write_pending)
);

// File: pbh_master.sv
/* far-side master: asks for the bus while want is high and ends
   own transfers with bus_done after dly+1 cycles; one clock. */
`timescale 1ns/1ps
module pbh_master (
    input  wire logic       ref_clk,
    input  wire logic       want,
    input  wire logic [3:0] dly,
    input  wire logic       bus_strobe_n,
    output logic            bus_takeover_req_n,
    output logic            bus_done
);
    logic [3:0] cnt_q;
    // changes land just after the edge, as a real master drives them
    always @(posedge ref_clk) begin
        bus_takeover_req_n <= !want;
        cnt_q <= bus_strobe_n ? 4'h0 : cnt_q + 4'h1;
        bus_done <= !bus_strobe_n && cnt_q == dly;
    end
endmodule : pbh_master

// File: pbh_hold_test.sv
/* bench for pbh_hold against the pbh_master far side.
   assumes port names match, so instances connect by name. */
`timescale 1ns/1ps
module pbh_hold_test;
    logic        ref_clk, sys_rst, want, takeover_disable, core_req, core_we, core_ready;
    logic        bus_takeover_req_n, bus_done, bus_takeover_ack_n, bus_strobe_n, bus_rw;
    logic        bus_strobe_oe_n, bus_rw_oe_n, bus_addr_oe_n, bus_data_oe_n, write_pending;
    logic [3:0]  dly;
    logic [23:0] core_addr, bus_addr;
    logic [31:0] core_wdata, bus_data_out;
    int          err_total, tests_run, n;
    pbh_hold i_dut (
        .ref_clk            (ref_clk),
        .sys_rst            (sys_rst),
        .bus_takeover_req_n (bus_takeover_req_n),
        .takeover_disable   (takeover_disable),
        .core_req           (core_req),
        .core_we            (core_we),
        .core_addr          (core_addr),
        .core_wdata         (core_wdata),
        .core_ready         (core_ready),
        .bus_done           (bus_done),
        .bus_takeover_ack_n (bus_takeover_ack_n),
        .bus_strobe_n       (bus_strobe_n),
        .bus_strobe_oe_n    (bus_strobe_oe_n),
        .bus_rw             (bus_rw),
        .bus_rw_oe_n        (bus_rw_oe_n),
        .bus_addr           (bus_addr),
        .bus_addr_oe_n      (bus_addr_oe_n),
        .bus_data_out       (bus_data_out),
        .bus_data_oe_n      (bus_data_oe_n),
        .write_pending      (write_pending)
    );
    pbh_master i_far (
        .ref_clk            (ref_clk),
        .want               (want),
        .dly                (dly),
        .bus_strobe_n       (bus_strobe_n),
        .bus_takeover_req_n (bus_takeover_req_n),
        .bus_done           (bus_done)
    );
    initial begin
        ref_clk = 1'b0;
        forever #20 ref_clk = !ref_clk;
    end
    task chk(input logic [31:0] s, input logic [31:0] e);
        tests_run++;
        if (s !== e) begin
            err_total++;
            $display("[ERR] %0t %h %h", $time, s, e);
        end
    endtask : chk
    task test_done;
        $display("%0d checks, %0d errors", tests_run, err_total);
        if (err_total == 0 && tests_run > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : test_done
    // falling edges until ack (0), strobe (1) or ready (2) reads v
    task wt(input int s, input logic v, output int c);
        c = 0;
        while ((s == 0 ? bus_takeover_ack_n : s == 1 ? bus_strobe_n : core_ready) !== v) begin
            @(negedge ref_clk);
            c++;
            if (c > 40) begin
                err_total++;
                test_done();
            end
        end
    endtask : wt
    task go(input logic we, input logic [23:0] a, input logic [31:0] d);
        int c;
        {core_req, core_we, core_addr, core_wdata} = {1'b1, we, a, d};
        #1;
        wt(2, 1, c);
        @(negedge ref_clk);
        core_req = 1'b0;
    endtask : go
    // grant timing, floating pins, one write parked and replayed on release
    task t_hold;
        want = 1'b1;
        wt(0, 0, n);
        chk(n, 4);
        chk({bus_strobe_oe_n, bus_rw_oe_n, bus_addr_oe_n, bus_data_oe_n}, 4'hf);
        go(1'b1, 24'h10, 32'hcafe0001);
        chk(write_pending, 1'b1);
        // a second write must stall while the first is parked
        @(negedge ref_clk);
        {core_req, core_we} = 2'h3;
        #1;
        chk(core_ready, 1'b0);
        @(negedge ref_clk);
        core_req = 1'b0;
        want = 1'b0;
        wt(0, 1, n);
        chk(n, 5);
        chk({bus_strobe_oe_n, bus_rw_oe_n, bus_addr_oe_n}, 3'h0);
        wt(1, 0, n);
        chk({bus_rw, bus_data_oe_n, bus_addr}, 26'h10);
        chk(bus_data_out, 32'hcafe0001);
        chk(write_pending, 1'b0);
        $display("hold test over");
    endtask : t_hold
    // grant waits out a slow read; a held read stalls until disable
    task t_gap;
        dly = 4'h5;
        go(1'b0, 24'habc, 32'h0);
        want = 1'b1;
        wt(0, 0, n);
        chk(n > 5, 1'b1);
        chk(bus_strobe_n, 1'b1);
        {core_req, core_we} = 2'h2;
        repeat (3) @(negedge ref_clk);
        chk(core_ready, 1'b0);
        takeover_disable = 1'b1;
        wt(2, 1, n);
        @(negedge ref_clk);
        core_req = 1'b0;
        chk(bus_takeover_ack_n, 1'b1);
        // request still asserted but disabled: no new grant, own read runs
        repeat (4) @(negedge ref_clk);
        chk(bus_takeover_ack_n, 1'b1);
        chk(bus_strobe_n, 1'b0);
        $display("gap test over");
    endtask : t_gap
    initial begin
        {sys_rst, want, takeover_disable, core_req, core_we, dly} = 9'h100;
        {core_addr, core_wdata} = 56'h0;
        repeat (5) @(negedge ref_clk);
        sys_rst = 1'b0;
        t_hold();
        t_gap();
        test_done();
    end
endmodule : pbh_hold_test
